// File: logic/bias_seq_pkg.sv
package bias_seq_pkg;
    // Delay timers
    localparam int DLY_W = 24;
    localparam logic [23:0] NEG_PUMP_DELAY_CYCLES_DEF = 24'h000400;
    localparam logic [23:0] POS_PUMP_DELAY_CYCLES_DEF = 24'h000400;
    // Switching rates
    localparam int CLK_HZ = 25000000;
    localparam int RATE_LO_HZ = 500000;
    localparam int RATE_HI_HZ = 750000;
    localparam int DIV_W = 6;
    localparam logic [5:0] DIV_LO = 6'(CLK_HZ / RATE_LO_HZ);
    localparam logic [5:0] DIV_HI = 6'(CLK_HZ / RATE_HI_HZ);
    localparam int SYNC_W = 12;

    typedef struct packed {
        logic logic_rail;
        logic neg_pump;
        logic pos_pump;
        logic amps;
        logic boost;
        logic gate_shaping;
    } rail_en_s;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_BUCK,
        ST_RUN
    } seq_state_e;

    typedef enum logic [1:0] {
        IL_OFF,
        IL_LIMIT,
        IL_SHORT
    } iso_state_e;

    typedef struct packed {
        logic fault_short;
        logic fault_ovp;
        logic thermal;
        logic uvlo;
    } event_s;
endpackage

// File: logic/lcd_bias_rail_sequencer.sv
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module lcd_bias_rail_sequencer #(
    parameter logic [23:0] NEG_PUMP_DELAY_CYCLES = bias_seq_pkg::NEG_PUMP_DELAY_CYCLES_DEF,
    parameter logic [23:0] POS_PUMP_DELAY_CYCLES = bias_seq_pkg::POS_PUMP_DELAY_CYCLES_DEF
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic logic_rail_enable_in,
    input wire logic boost_enable_in,
    input wire logic gate_shaping_control_in,
    input wire logic switch_rate_select,
    input wire logic thermal_trip,
    input wire logic uvlo_trip,
    input wire logic buck_pgood,
    input wire logic pos_pump_pgood,
    input wire logic neg_pump_delay_done,
    input wire logic pos_pump_delay_done,
    input wire logic drop_below_0v5,
    input wire logic drop_above_1v4,
    input wire logic drop_at_3v,
    input wire logic boost_ovp,
    input wire logic soft_start_done,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    output logic irq,
    output bias_seq_pkg::rail_en_s rail_en,
    output logic neg_pump_delay_run,
    output logic pos_pump_delay_run,
    output logic boost_switch_en,
    output logic iso_current_limit,
    output logic boost_full_ilimit,
    output logic switch_clk
);

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic [11:0] meta_q;
    logic [11:0] sync_q;
    logic [11:0] pins;
    assign pins = {logic_rail_enable_in, boost_enable_in, gate_shaping_control_in, switch_rate_select,
                   thermal_trip, uvlo_trip, buck_pgood, pos_pump_pgood, neg_pump_delay_done,
                   pos_pump_delay_done, drop_below_0v5, drop_above_1v4};
    logic [2:0] meta2_q;
    logic [2:0] sync2_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta_q <= 12'h000;
            sync_q <= 12'h000;
            meta2_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            meta2_q <= {drop_at_3v, boost_ovp, soft_start_done};
            sync2_q <= meta2_q;
        end
    end

    logic en1_s, en2_s, gsc_s, rate_s, therm_s, uvlo_s, bpg_s, ppg_s, d1_s, d2_s, lt05_s, gt14_s;
    logic ge3_s, ovp_s, ss_s;
    assign {en1_s, en2_s, gsc_s, rate_s, therm_s, uvlo_s, bpg_s, ppg_s, d1_s, d2_s, lt05_s, gt14_s} = sync_q;
    assign {ge3_s, ovp_s, ss_s} = sync2_q;

    // --------------------------------------------------------------
    // Sequencer
    // --------------------------------------------------------------
    logic shutdown;
    assign shutdown = therm_s | uvlo_s | ~en1_s;

    bias_seq_pkg::seq_state_e state_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || shutdown) begin
            state_q <= bias_seq_pkg::ST_OFF;
        end else begin
            case (state_q)
                bias_seq_pkg::ST_OFF: state_q <= bias_seq_pkg::ST_BUCK;
                bias_seq_pkg::ST_BUCK: if (bpg_s) state_q <= bias_seq_pkg::ST_RUN;
                bias_seq_pkg::ST_RUN: state_q <= bias_seq_pkg::ST_RUN;
                default: state_q <= bias_seq_pkg::ST_OFF;
            endcase
        end
    end

    logic running;
    assign running = (state_q == bias_seq_pkg::ST_RUN);

    // Second enable edge detection, taken from the synchronised level
    logic en2_prev_q;
    logic en2_rise;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            en2_prev_q <= 1'b0;
        end else begin
            en2_prev_q <= en2_s;
        end
    end
    assign en2_rise = en2_s & ~en2_prev_q;

    // --------------------------------------------------------------
    // Delay timers
    // --------------------------------------------------------------
    logic [23:0] neg_pump_delay_cnt_q;
    logic [23:0] pos_pump_delay_cnt_q;
    logic neg_pump_delay_done_q;
    logic pos_pump_delay_done_q;

    function automatic logic expired(input logic [23:0] cnt, input logic [23:0] lim, input logic cmp);
        expired = cmp || (cnt >= lim);
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !running) begin
            neg_pump_delay_cnt_q <= 24'h000000;
            neg_pump_delay_done_q <= 1'b0;
        end else if (!neg_pump_delay_done_q) begin
            neg_pump_delay_cnt_q <= neg_pump_delay_cnt_q + 24'h000001;
            neg_pump_delay_done_q <= expired(neg_pump_delay_cnt_q, NEG_PUMP_DELAY_CYCLES, d1_s);
        end
    end

    // Delay two waits for the second enable and restarts on its rising edge
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !running || !en2_s) begin
            pos_pump_delay_cnt_q <= 24'h000000;
            pos_pump_delay_done_q <= 1'b0;
        end else if (en2_rise) begin
            pos_pump_delay_cnt_q <= 24'h000000;
            pos_pump_delay_done_q <= 1'b0;
        end else if (!pos_pump_delay_done_q) begin
            pos_pump_delay_cnt_q <= pos_pump_delay_cnt_q + 24'h000001;
            pos_pump_delay_done_q <= expired(pos_pump_delay_cnt_q, POS_PUMP_DELAY_CYCLES, d2_s);
        end
    end

    // --------------------------------------------------------------
    // Isolation switch and boost protection
    // --------------------------------------------------------------
    bias_seq_pkg::iso_state_e iso_q;
    logic boost_on;
    assign boost_on = running & en2_s;

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !boost_on) begin
            iso_q <= bias_seq_pkg::IL_OFF;
        end else begin
            case (iso_q)
                bias_seq_pkg::IL_OFF: iso_q <= bias_seq_pkg::IL_LIMIT;
                bias_seq_pkg::IL_LIMIT: if (lt05_s) iso_q <= bias_seq_pkg::IL_SHORT;
                // Full operation: a drop above 1.4 V is a shorted output
                bias_seq_pkg::IL_SHORT: if (gt14_s) iso_q <= bias_seq_pkg::IL_LIMIT;
                default: iso_q <= bias_seq_pkg::IL_OFF;
            endcase
        end
    end

    logic full_op;
    assign full_op = (iso_q == bias_seq_pkg::IL_SHORT);

    // --------------------------------------------------------------
    // Switching clock, common to all converters
    // --------------------------------------------------------------
    logic [5:0] div_cnt_q;
    logic [5:0] div_lim;
    assign div_lim = rate_s ? bias_seq_pkg::DIV_HI : bias_seq_pkg::DIV_LO;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_cnt_q <= 6'h00;
            switch_clk <= 1'b0;
        end else if (div_cnt_q >= div_lim - 6'h01) begin
            div_cnt_q <= 6'h00;
            switch_clk <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
            switch_clk <= (div_cnt_q < (div_lim >> 1)) ? 1'b1 : 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Enable outputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || shutdown) begin
            rail_en <= '0;
            neg_pump_delay_run <= 1'b0;
            pos_pump_delay_run <= 1'b0;
            boost_switch_en <= 1'b0;
            iso_current_limit <= 1'b0;
            boost_full_ilimit <= 1'b0;
        end else begin
            rail_en.logic_rail <= 1'b1;
            rail_en.neg_pump <= neg_pump_delay_done_q;
            rail_en.pos_pump <= pos_pump_delay_done_q;
            rail_en.amps <= pos_pump_delay_done_q;
            rail_en.boost <= boost_on;
            rail_en.gate_shaping <= ppg_s & gsc_s & pos_pump_delay_done_q;
            neg_pump_delay_run <= running & ~neg_pump_delay_done_q;
            pos_pump_delay_run <= running & en2_s & ~pos_pump_delay_done_q;
            // Constant-frequency CCM: gated only by boost_on, full operation and the protections, no skip logic
            boost_switch_en <= boost_on & full_op & lt05_s & ~ovp_s & ~gt14_s;
            iso_current_limit <= boost_on & ge3_s;
            boost_full_ilimit <= boost_on & ss_s;
        end
    end

    // --------------------------------------------------------------
    // Event status, mask and register port
    // --------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h4;
    localparam logic [3:0] ADDR_STATE = 4'h8;

    bias_seq_pkg::event_s ev;
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic full_op_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            full_op_q <= 1'b0;
        end else begin
            full_op_q <= full_op;
        end
    end
    assign ev.fault_short = full_op_q & ~full_op & boost_on;
    assign ev.fault_ovp = ovp_s & boost_on;
    assign ev.thermal = therm_s;
    assign ev.uvlo = uvlo_s;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status_q <= 4'h0;
        end else if (wr_stb && addr == ADDR_STATUS) begin
            // Set wins over a simultaneous clear
            status_q <= (status_q & ~wdata[3:0]) | ev;
        end else begin
            status_q <= status_q | ev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask_q <= 4'h0;
        end else if (wr_stb && addr == ADDR_MASK) begin
            mask_q <= wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata <= 32'h00000000;
        end else if (rd_stb) begin
            case (addr)
                ADDR_STATUS: rdata <= {28'h0000000, status_q};
                ADDR_MASK: rdata <= {28'h0000000, mask_q};
                ADDR_STATE: rdata <= {24'h000000, iso_q, state_q, pos_pump_delay_done_q, neg_pump_delay_done_q, rail_en.boost,
                                      rail_en.logic_rail};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    uvlo_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(uvlo_s) |-> rail_en == '0) else $error("rail enabled during undervoltage");
    therm_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(therm_s) |-> !boost_switch_en && !rail_en.logic_rail) else $error("rail on in thermal");
    buck_first_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rail_en.neg_pump |-> rail_en.logic_rail) else $error("pump before buck");
    neg_after_dly_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(rail_en.neg_pump) |-> $past(neg_pump_delay_done_q)) else $error("negative pump early");
    boost_cond_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rail_en.boost |-> $past(en2_s) && $past(running)) else $error("boost without conditions");
    pos_amps_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rail_en.pos_pump == rail_en.amps) else $error("pump and amps split");
    en2_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        en2_rise && running |=> pos_pump_delay_cnt_q == 24'h000000) else $error("delay two not restarted");
    gate_shape_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rail_en.gate_shaping |-> $past(ppg_s) && $past(gsc_s)) else $error("gate shaping early");
    ovp_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $past(ovp_s) |-> !boost_switch_en) else $error("switching during overvoltage");
    iso_limit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(ge3_s) |-> !iso_current_limit) else $error("limit below 3 V");
    drop_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !$past(lt05_s) |-> !boost_switch_en) else $error("switching with high drop");

    seq_full_c: cover property (@(posedge clk_sys) disable iff (!rst_b) rail_en.gate_shaping);
    boost_run_c: cover property (@(posedge clk_sys) disable iff (!rst_b) boost_switch_en);
    short_trip_c: cover property (@(posedge clk_sys) disable iff (!rst_b) ev.fault_short);

endmodule // lcd_bias_rail_sequencer

// File: bench/test_lcd_bias_rail_sequencer.sv
`timescale 1ns/1ps
module test_lcd_bias_rail_sequencer;
    localparam logic [23:0] D1 = 24'h000008;
    localparam logic [23:0] D2 = 24'h000030;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic logic_rail_enable_in = 1'b0, boost_enable_in = 1'b0, gate_shaping_control_in = 1'b0;
    logic switch_rate_select = 1'b0, thermal_trip = 1'b0, uvlo_trip = 1'b0, buck_pgood = 1'b0;
    logic pos_pump_pgood = 1'b0, neg_pump_delay_done = 1'b0, pos_pump_delay_done = 1'b0;
    logic drop_below_0v5 = 1'b0, drop_above_1v4 = 1'b0, drop_at_3v = 1'b0;
    logic boost_ovp = 1'b0, soft_start_done = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic irq, neg_pump_delay_run, pos_pump_delay_run, boost_switch_en, iso_current_limit;
    logic boost_full_ilimit, switch_clk;
    bias_seq_pkg::rail_en_s rail_en;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #20 clk_sys = ~clk_sys;

    lcd_bias_rail_sequencer #(.NEG_PUMP_DELAY_CYCLES(D1), .POS_PUMP_DELAY_CYCLES(D2)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .logic_rail_enable_in(logic_rail_enable_in),
        .boost_enable_in(boost_enable_in), .gate_shaping_control_in(gate_shaping_control_in),
        .switch_rate_select(switch_rate_select), .thermal_trip(thermal_trip), .uvlo_trip(uvlo_trip),
        .buck_pgood(buck_pgood), .pos_pump_pgood(pos_pump_pgood), .neg_pump_delay_done(neg_pump_delay_done),
        .pos_pump_delay_done(pos_pump_delay_done), .drop_below_0v5(drop_below_0v5),
        .drop_above_1v4(drop_above_1v4), .drop_at_3v(drop_at_3v), .boost_ovp(boost_ovp),
        .soft_start_done(soft_start_done), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .irq(irq), .rail_en(rail_en), .neg_pump_delay_run(neg_pump_delay_run),
        .pos_pump_delay_run(pos_pump_delay_run), .boost_switch_en(boost_switch_en),
        .iso_current_limit(iso_current_limit), .boost_full_ilimit(boost_full_ilimit), .switch_clk(switch_clk));

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard, well above the fewer than a thousand cycles the scenarios need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Checks run right after an edge and so see the values settled before it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        @(posedge clk_sys);
        chk(rdata, exp);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        cyc(2);
        chk({22'h0, rail_en, neg_pump_delay_run, pos_pump_delay_run, boost_switch_en, irq}, 32'h0);
        wr(4'hc, 32'h0000000f);
        rd(4'hc, 32'h0);
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
    endtask

    task t_start;
        logic_rail_enable_in <= 1'b1;
        boost_enable_in <= 1'b1;
        cyc(2);
        chk(rail_en.logic_rail, 1'b0);
        cyc(8);
        chk(rail_en.logic_rail, 1'b1);
        chk({rail_en.neg_pump, rail_en.pos_pump, rail_en.boost, neg_pump_delay_run}, 4'h0);
        chk(rail_en.boost, 1'b0);
        buck_pgood <= 1'b1;
        cyc(7);
        chk({neg_pump_delay_run, pos_pump_delay_run, rail_en.neg_pump}, 3'b110);
        chk(rail_en.boost, 1'b1);
        cyc(18);
        chk({rail_en.neg_pump, rail_en.pos_pump, rail_en.amps}, 3'b100);
        cyc(50);
        chk({rail_en.pos_pump, rail_en.amps}, 2'b11);
    endtask

    task t_boost;
        cyc(6);
        chk(boost_switch_en, 1'b0);
        drop_at_3v <= 1'b1;
        cyc(6);
        chk(iso_current_limit, 1'b1);
        drop_at_3v <= 1'b0;
        drop_below_0v5 <= 1'b1;
        cyc(6);
        chk(iso_current_limit, 1'b0);
        chk(boost_switch_en, 1'b1);
        boost_ovp <= 1'b1;
        cyc(6);
        chk(boost_switch_en, 1'b0);
        rd(4'h0, 32'h4);
        boost_ovp <= 1'b0;
        cyc(6);
        chk(boost_switch_en, 1'b1);
        chk(boost_full_ilimit, 1'b0);
        soft_start_done <= 1'b1;
        cyc(6);
        chk(boost_full_ilimit, 1'b1);
    endtask

    task next_rise(output int n);
        logic prev;
        logic rose;
        n = 0;
        prev = switch_clk;
        do begin
            @(posedge clk_sys);
            n++;
            rose = switch_clk & ~prev;
            prev = switch_clk;
        end while (!rose && n < 200);
    endtask

    task measure(input logic sel, input logic [5:0] div);
        int n;
        switch_rate_select <= sel;
        cyc(100);
        next_rise(n);
        next_rise(n);
        chk(n, 32'(div));
        next_rise(n);
        chk(n, 32'(div));
    endtask

    task t_short;
        wr(4'h0, 32'hf);
        drop_below_0v5 <= 1'b0;
        drop_above_1v4 <= 1'b1;
        cyc(6);
        chk(boost_switch_en, 1'b0);
        rd(4'h0, 32'h8);
        drop_above_1v4 <= 1'b0;
    endtask

    task t_fault(input int i);
        wr(4'h0, 32'hf);
        if (i == 0) uvlo_trip <= 1'b1;
        else thermal_trip <= 1'b1;
        cyc(6);
        chk({23'h0, rail_en, neg_pump_delay_run, pos_pump_delay_run, boost_switch_en}, 32'h0);
        rd(4'h0, 32'(1 << i));
        chk(irq, 1'b0);
        wr(4'h4, 32'(1 << i));
        cyc(3);
        chk(irq, 1'b1);
        wr(4'h0, 32'(1 << i));
        rd(4'h0, 32'(1 << i));
        uvlo_trip <= 1'b0;
        thermal_trip <= 1'b0;
        // Hold the buck below power-good so the restart can be seen in its first step
        buck_pgood <= 1'b0;
        // Let the released fault clear the synchroniser before clearing its status bit
        cyc(4);
        wr(4'h0, 32'(1 << i));
        cyc(3);
        chk(irq, 1'b0);
        wr(4'h4, 32'h0);
        cyc(8);
        chk({rail_en.logic_rail, rail_en.neg_pump}, 2'b10);
        buck_pgood <= 1'b1;
        cyc(25);
        chk(rail_en.neg_pump, 1'b1);
    endtask

    task t_late_en2;
        boost_enable_in <= 1'b0;
        logic_rail_enable_in <= 1'b0;
        cyc(6);
        chk(32'(rail_en), 32'h0);
        logic_rail_enable_in <= 1'b1;
        cyc(70);
        chk({rail_en.neg_pump, rail_en.pos_pump, rail_en.boost}, 3'b100);
        boost_enable_in <= 1'b1;
        cyc(20);
        chk({pos_pump_delay_run, rail_en.pos_pump}, 2'b10);
        pos_pump_delay_done <= 1'b1;
        cyc(6);
        chk({rail_en.pos_pump, rail_en.amps}, 2'b11);
        pos_pump_delay_done <= 1'b0;
    endtask

    task t_gate;
        gate_shaping_control_in <= 1'b1;
        cyc(6);
        chk(rail_en.gate_shaping, 1'b0);
        pos_pump_pgood <= 1'b1;
        cyc(6);
        chk(rail_en.gate_shaping, 1'b1);
        gate_shaping_control_in <= 1'b0;
        cyc(6);
        chk(rail_en.gate_shaping, 1'b0);
    endtask

    initial begin
        cyc(5);
        rst_b <= 1'b1;
        t_reset();
        t_start();
        t_boost();
        measure(1'b0, bias_seq_pkg::DIV_LO);
        measure(1'b1, bias_seq_pkg::DIV_HI);
        t_short();
        t_fault(0);
        t_fault(1);
        t_late_en2();
        t_gate();
        print_verdict();
    end
endmodule // test_lcd_bias_rail_sequencer
